// *** desp_top.sv ***
`timescale 1ns/1ps
module desp_top
  import desp_pkg::*;
#(
  parameter logic [7:0] MOTOR_KIND = DESP_KIND_STEP
)
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [5:0]  fault_level,
  input  wire logic        wrong_dir,
  input  wire logic        err_push,
  input  wire logic [7:0]  err_number,
  input  wire logic [15:0] err_code,
  input  wire logic        od_req,
  input  wire logic        od_write,
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_subindex,
  input  wire logic [31:0] od_wdata,
  output logic             od_ack,
  output logic             od_abort,
  output logic      [31:0] od_rdata,
  output logic      [7:0]  fault_category_flags,
  output logic      [7:0]  fault_history_count
);

  ////////////////////////////////////////////////////////////////////////
  // Submodules

  logic [31:0] hist_entry;
  logic [31:0] push_entry;
  logic        count_clear;
  logic [2:0]  rd_slot;
  logic [7:0]  flags;
  logic [7:0]  count;

  desp_flags u_flags (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .fault_level (fault_level),
    .wrong_dir   (wrong_dir),
    .flags       (flags)
  );

  // Class byte mirrors the live flags at the time of the error
  assign push_entry = {err_number, flags, err_code};

  desp_hist u_hist (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .push        (err_push),
    .push_entry  (push_entry),
    .count_clear (count_clear),
    .rd_slot     (rd_slot),
    .rd_entry    (hist_entry),
    .count       (count)
  );

  ////////////////////////////////////////////////////////////////////////
  // Object access decode

  logic        ack_r;
  logic        ack_nxt;
  logic        abort_r;
  logic        abort_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        sub_is_entry;

  assign sub_is_entry = (od_subindex >= 8'h01) && (od_subindex <= DESP_COUNT_MAX);
  assign rd_slot      = 3'(od_subindex - 8'h01);
  // Only a zero write restarts counting; other values are refused
  assign count_clear  = od_req && od_write && (od_index == DESP_IDX_HIST)
                        && (od_subindex == DESP_SUB_COUNT) && (od_wdata == 32'h0000_0000);

  // One answer per request, the cycle after; abort carries its code on rdata
  always_comb
  begin
    ack_nxt   = od_req;
    abort_nxt = 1'b0;
    rdata_nxt = 32'h0000_0000;
    if (od_req)
    begin
      case (od_index)
        DESP_IDX_KIND:
        begin
          if (od_subindex != DESP_SUB_COUNT)
          begin
            abort_nxt = 1'b1;
            rdata_nxt = DESP_ABORT_NOSUB;
          end
          else if (od_write)
          begin
            abort_nxt = 1'b1;
            rdata_nxt = DESP_ABORT_RO;
          end
          else
            rdata_nxt = {8'h00, MOTOR_KIND, DESP_PROFILE};
        end
        DESP_IDX_FLAGS:
        begin
          if (od_subindex != DESP_SUB_COUNT)
          begin
            abort_nxt = 1'b1;
            rdata_nxt = DESP_ABORT_NOSUB;
          end
          else if (od_write)
          begin
            abort_nxt = 1'b1;
            rdata_nxt = DESP_ABORT_RO;
          end
          else
            rdata_nxt = {24'h000000, flags};
        end
        DESP_IDX_HIST:
        begin
          if (od_subindex == DESP_SUB_COUNT)
          begin
            if (od_write && (od_wdata != 32'h0000_0000))
            begin
              abort_nxt = 1'b1;
              rdata_nxt = DESP_ABORT_VALUE;
            end
            else if (!od_write)
              rdata_nxt = {24'h000000, count};
          end
          else if (!sub_is_entry)
          begin
            abort_nxt = 1'b1;
            rdata_nxt = DESP_ABORT_NOSUB;
          end
          else if (od_write)
          begin
            abort_nxt = 1'b1;
            rdata_nxt = DESP_ABORT_RO;
          end
          else if (count == DESP_COUNT_RST)
          begin
            abort_nxt = 1'b1;
            rdata_nxt = DESP_ABORT_EMPTY;
          end
          else
            rdata_nxt = hist_entry;
        end
        default:
        begin
          abort_nxt = 1'b1;
          rdata_nxt = DESP_ABORT_NOOBJ;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ack_r   <= 1'b0;
      abort_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r   <= ack_nxt;
      abort_r <= abort_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign od_ack               = ack_r;
  assign od_abort             = abort_r;
  assign od_rdata             = rdata_r;
  assign fault_category_flags = flags;
  assign fault_history_count  = count;

endmodule : desp_top

// *** desp_pkg.sv ***
// Summary of operation
// - Read-only 32-bit type word: upper half motor kind, lower half profile number.
// - Motor kind in bits 23..16 is 1 for servo, 2 for stepper.
// - Profile number half reads 0192h, the standard motion drive profile.
// - Fault flags bit order: general, current, voltage, temp, link, profile, zero, vendor.
// - Flag bits follow live fault conditions; reset to zero; read-only.
// - Vendor bit 7 is set while the motor turns in the wrong direction.
// - History stack holds up to eight 32-bit entries at sub-entries 1 to 8.
// - History entries are read-only and reset to zero.
// - New error goes to entry 1, older ones shift deeper, oldest dropped.
// - Count at sub-entry 0 is 8-bit read/write; writing zero restarts counting.
// - Reading an entry while the stack is empty aborts with 08000024h.
// - Entry layout: number 31..24, class 23..16 from flags, code 15..0.
package desp_pkg;

  localparam logic [15:0] DESP_IDX_KIND   = 16'h1000;
  localparam logic [15:0] DESP_IDX_FLAGS  = 16'h1001;
  localparam logic [15:0] DESP_IDX_HIST   = 16'h1003;
  localparam logic [7:0]  DESP_SUB_COUNT  = 8'h00;
  localparam int          DESP_DEPTH      = 8;
  localparam logic [7:0]  DESP_COUNT_MAX  = 8'h08;
  localparam logic [7:0]  DESP_COUNT_RST  = 8'h00;
  localparam logic [7:0]  DESP_FLAGS_RST  = 8'h00;
  localparam logic [31:0] DESP_ENTRY_RST  = 32'h0000_0000;
  localparam logic [15:0] DESP_PROFILE    = 16'h0192;
  localparam logic [7:0]  DESP_KIND_SERVO = 8'h01;
  localparam logic [7:0]  DESP_KIND_STEP  = 8'h02;
  localparam logic [31:0] DESP_ABORT_EMPTY = 32'h0800_0024;
  localparam logic [31:0] DESP_ABORT_NOOBJ = 32'h0602_0000;
  localparam logic [31:0] DESP_ABORT_NOSUB = 32'h0609_0011;
  localparam logic [31:0] DESP_ABORT_RO    = 32'h0601_0002;
  localparam logic [31:0] DESP_ABORT_VALUE = 32'h0609_0030;

  // Fault flag bit positions
  localparam int DESP_BIT_GEN  = 0;
  localparam int DESP_BIT_CUR  = 1;
  localparam int DESP_BIT_VOL  = 2;
  localparam int DESP_BIT_TEMP = 3;
  localparam int DESP_BIT_LINK = 4;
  localparam int DESP_BIT_PROFILE_FAULT_FLAG = 5;
  localparam int DESP_BIT_RES  = 6;
  localparam int DESP_BIT_VEND = 7;

  // History entry field positions
  localparam int DESP_NUM_LSB   = 24;
  localparam int DESP_CLASS_LSB = 16;
  localparam int DESP_CODE_LSB  = 0;

endpackage : desp_pkg

// *** desp_flags.sv ***
`timescale 1ns/1ps
module desp_flags
  import desp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [5:0] fault_level,
  input  wire logic       wrong_dir,
  output logic      [7:0] flags
);

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // Flags track live conditions, no latching
  always_comb
  begin
    flags_nxt                = DESP_FLAGS_RST;
    flags_nxt[DESP_BIT_GEN]  = fault_level[DESP_BIT_GEN];
    flags_nxt[DESP_BIT_CUR]  = fault_level[DESP_BIT_CUR];
    flags_nxt[DESP_BIT_VOL]  = fault_level[DESP_BIT_VOL];
    flags_nxt[DESP_BIT_TEMP] = fault_level[DESP_BIT_TEMP];
    flags_nxt[DESP_BIT_LINK] = fault_level[DESP_BIT_LINK];
    flags_nxt[DESP_BIT_PROFILE_FAULT_FLAG] = fault_level[DESP_BIT_PROFILE_FAULT_FLAG];
    flags_nxt[DESP_BIT_RES]  = 1'b0;
    flags_nxt[DESP_BIT_VEND] = wrong_dir;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      flags_r <= DESP_FLAGS_RST;
    else
      flags_r <= flags_nxt;
  end

  assign flags = flags_r;

endmodule : desp_flags

// *** desp_hist.sv ***
`timescale 1ns/1ps
module desp_hist
  import desp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        push,
  input  wire logic [31:0] push_entry,
  input  wire logic        count_clear,
  input  wire logic [2:0]  rd_slot,
  output logic      [31:0] rd_entry,
  output logic      [7:0]  count
);

  logic [31:0] stack_r   [DESP_DEPTH];
  logic [31:0] stack_nxt [DESP_DEPTH];
  logic [7:0]  count_r;
  logic [7:0]  count_nxt;

  // Shift register: slot 0 is newest, last slot falls off
  generate
    for (genvar i = 0; i < DESP_DEPTH; i++)
    begin : g_slot
      always_comb
      begin
        stack_nxt[i] = stack_r[i];
        if (push)
          stack_nxt[i] = (i == 0) ? push_entry : stack_r[(i == 0) ? 0 : i - 1];
      end

      always_ff @(posedge sys_clk)
      begin
        if (srst)
          stack_r[i] <= DESP_ENTRY_RST;
        else
          stack_r[i] <= stack_nxt[i];
      end
    end
  endgenerate

  // Clear restarts counting; a push in the same cycle still counts as one
  always_comb
  begin
    count_nxt = count_r;
    if (count_clear)
      count_nxt = DESP_COUNT_RST;
    if (push)
    begin
      if (count_nxt < DESP_COUNT_MAX)
        count_nxt = count_nxt + 8'h01;
      else
        count_nxt = DESP_COUNT_MAX;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      count_r <= DESP_COUNT_RST;
    else
      count_r <= count_nxt;
  end

  assign rd_entry = stack_r[rd_slot];
  assign count    = count_r;

endmodule : desp_hist

// *** desp_mst.sv ***
`timescale 1ns/1ps
module desp_mst
(
  input  logic        sys_clk,
  output logic        od_req,
  output logic        od_write,
  output logic [15:0] od_index,
  output logic [7:0]  od_subindex,
  output logic [31:0] od_wdata,
  input  logic        od_ack,
  input  logic        od_abort,
  input  logic [31:0] od_rdata
);
  // Idle request lines at time zero
  initial
  begin
    od_req = 1'b0;
    od_write = 1'b0;
    od_index = 16'h0000;
    od_subindex = 8'h00;
    od_wdata = 32'h0;
  end

  ////////////////////////////////////////
  // One request pulse, then a bounded wait so a dead device cannot hang us
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, output logic [32:0] res, output logic ok);
    res = 'x;
    ok = 1'b0;
    od_write = wr;
    od_index = idx;
    od_subindex = sub;
    od_wdata = wd;
    od_req = 1'b1;
    // Answer is looked at on falling edges, where the registered ack has settled
    for (int i = 0; i < 4; i++)
    begin
      @(negedge sys_clk);
      if (i == 0)
      begin
        od_req = 1'b0;
        od_index = ~idx; // Stale index and data are scrambled, not left looking valid
        od_wdata = ~wd;
      end
      if (od_ack === 1'b1)
      begin
        res = {od_abort, od_rdata};
        ok = 1'b1;
        break;
      end
    end
    @(negedge sys_clk);
  endtask : xfer
endmodule : desp_mst

// *** desp_sva.sv ***
`timescale 1ns/1ps
module desp_sva
(
  input logic        sys_clk,
  input logic        srst,
  input logic [5:0]  fault_level,
  input logic        wrong_dir,
  input logic        err_push,
  input logic        od_req,
  input logic        od_write,
  input logic [15:0] od_index,
  input logic [7:0]  od_subindex,
  input logic [31:0] od_wdata,
  input logic        od_ack,
  input logic        od_abort,
  input logic [31:0] od_rdata,
  input logic [7:0]  fault_category_flags,
  input logic [7:0]  fault_history_count
);
  // One clock domain, reset masks every check
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // Decoded requests
  sequence s_rd(idx);
    od_req && !od_write && od_index == idx;
  endsequence
  sequence s_clr;
    od_req && od_write && od_index == 16'h1003 && od_subindex == 8'h00 && od_wdata == 32'h0;
  endsequence

  ////////////////////////////////////////
  property p_kind;
    s_rd(16'h1000) ##0 od_subindex == 8'h00 |=> !od_abort && od_rdata[31:24] == 8'h00
      && od_rdata[23:16] inside {8'h01, 8'h02} && od_rdata[15:0] == 16'h0192;
  endproperty
  a_kind: assert property (p_kind) else $error("type word wrong");
  property p_res;
    fault_category_flags[6] == 1'b0;
  endproperty
  a_res: assert property (p_res) else $error("reserved flag set");
  property p_flags;
    1 |=> fault_category_flags == {$past(wrong_dir), 1'b0, $past(fault_level)};
  endproperty
  a_flags: assert property (p_flags) else $error("flags not following faults");
  property p_push;
    err_push && !(od_req && od_write) && fault_history_count < 8'h08
      |=> fault_history_count == $past(fault_history_count) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("count not advanced");
  property p_sat;
    err_push && !(od_req && od_write) && fault_history_count == 8'h08
      |=> fault_history_count == 8'h08;
  endproperty
  a_sat: assert property (p_sat) else $error("count past eight");
  // A push in the same cycle counts on top of the clear, so only a lone clear is judged here
  property p_clr;
    s_clr ##0 !err_push |=> od_ack && !od_abort && fault_history_count == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("count clear failed");
  property p_empty;
    s_rd(16'h1003) ##0 od_subindex inside {[8'h01:8'h08]} && fault_history_count == 8'h00
      |=> od_abort && od_rdata == 32'h0800_0024;
  endproperty
  a_empty: assert property (p_empty) else $error("empty read not refused");
  property p_ro;
    od_req && od_write && (od_index == 16'h1001 && od_subindex == 8'h00
      || od_index == 16'h1003 && od_subindex inside {[8'h01:8'h08]})
      |=> od_ack && od_abort && od_rdata == 32'h0601_0002;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write accepted");
endmodule : desp_sva

bind desp_top desp_sva i_sva (.*);

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import desp_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        wrong_dir = 1'b0;
  logic        err_push = 1'b0;
  logic [5:0]  fault_level = 6'h00;
  logic [7:0]  err_number = 8'h00;
  logic [15:0] err_code = 16'h0000;
  logic        od_req, od_write, od_ack, od_abort, ok;
  logic [15:0] od_index;
  logic [7:0]  od_subindex, fault_category_flags, fault_history_count;
  logic [31:0] od_wdata, od_rdata;
  logic [32:0] res;
  int          n_fail = 0;
  int          total_checks = 0;

  // Servo kind chosen so the type word differs from the default build
  desp_top #(.MOTOR_KIND(DESP_KIND_SERVO)) i_dut (.*);
  desp_mst i_mst (.*);

  // 200 MHz core clock
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // A clean write answers with zero data, so the whole answer is judged
  task automatic op(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                    input logic [31:0] wd, input logic [32:0] exp);
    i_mst.xfer(wr, idx, sub, wd, res, ok);
    if (ok !== 1'b1)
    begin
      n_fail++;
      test_done();
    end
    else
      chk(res, exp);
  endtask : op

  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [32:0] exp);
    op(1'b0, idx, sub, 32'h0, exp);
  endtask : rd

  task automatic push(input logic [7:0] num);
    err_number = num;
    err_code = {8'h10, num};
    err_push = 1'b1;
    @(negedge sys_clk);
    err_push = 1'b0;
  endtask : push

  ////////////////////////////////////////
  task automatic t_kind();
    rd(16'h1000, 8'h00, {9'h0, DESP_KIND_SERVO, DESP_PROFILE});
    op(1'b1, 16'h1000, 8'h00, 32'h1, {1'b1, DESP_ABORT_RO});
    rd(16'h1000, 8'h01, {1'b1, DESP_ABORT_NOSUB});
    rd(16'h1002, 8'h00, {1'b1, DESP_ABORT_NOOBJ});
  endtask : t_kind

  task automatic t_flags();
    for (int i = 0; i < 6; i++)
    begin
      fault_level = 6'h01 << i;
      @(negedge sys_clk);
      rd(16'h1001, 8'h00, {25'h0, 8'h01 << i});
    end
    fault_level = 6'h3f;
    wrong_dir = 1'b1;
    @(negedge sys_clk);
    rd(16'h1001, 8'h00, {25'h0, 8'hbf});
    fault_level = 6'h00;
    wrong_dir = 1'b0;
    @(negedge sys_clk);
    rd(16'h1001, 8'h00, 33'h0);
    op(1'b1, 16'h1001, 8'h00, 32'h1, {1'b1, DESP_ABORT_RO});
    rd(16'h1001, 8'h01, {1'b1, DESP_ABORT_NOSUB});
  endtask : t_flags

  task automatic t_hist();
    rd(16'h1003, 8'h00, 33'h0);
    rd(16'h1003, 8'h01, {1'b1, DESP_ABORT_EMPTY});
    fault_level = 6'h04;
    @(negedge sys_clk);
    push(8'h01);
    rd(16'h1003, 8'h01, {9'h001, 8'h04, 8'h10, 8'h01});
    rd(16'h1003, 8'h02, 33'h0);
    for (int k = 2; k < 10; k++)
      push(8'(k));
    rd(16'h1003, 8'h00, {25'h0, DESP_COUNT_MAX});
    for (int n = 1; n < 9; n++)
      rd(16'h1003, 8'(n), {1'b0, 8'(10 - n), 8'h04, 8'h10, 8'(10 - n)});
    op(1'b1, 16'h1003, 8'h01, 32'h5, {1'b1, DESP_ABORT_RO});
    rd(16'h1003, 8'h09, {1'b1, DESP_ABORT_NOSUB});
    rd(16'h1003, 8'h01, {9'h009, 8'h04, 8'h10, 8'h09});
    op(1'b1, 16'h1003, 8'h00, 32'h1, {1'b1, DESP_ABORT_VALUE});
    op(1'b1, 16'h1003, 8'h00, 32'h0, 33'h0);
    rd(16'h1003, 8'h00, 33'h0);
    rd(16'h1003, 8'h01, {1'b1, DESP_ABORT_EMPTY});
  endtask : t_hist

  // Mid-run reset must wipe the stored entries, not only the count
  task automatic t_rst();
    push(8'h1f);
    srst = 1'b1;
    @(negedge sys_clk);
    srst = 1'b0;
    rd(16'h1003, 8'h00, 33'h0);
    push(8'h20);
    rd(16'h1003, 8'h01, {9'h020, 8'h04, 8'h10, 8'h20});
    rd(16'h1003, 8'h02, 33'h0);
  endtask : t_rst

  // Reset for three cycles, then the scenarios in turn
  initial
  begin
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    t_kind();
    t_flags();
    t_hist();
    t_rst();
    test_done();
  end
endmodule : tb_top
